//--- hw/sysi_top.sv
`timescale 1ns/10ps
// Function
// R1 - second pending register shows sources 14..8 in bits 7..1, bit 0 zero
// R2 - third pending register shows sources 16..15 low, upper six bits zero
// R3 - all reset sources act at once with equal top priority
// R4 - break interrupt forces cpu to software interrupt vector, break state
// R5 - in break, flags clear only when break clear enable is 1; the code still clears break exited wait and reset status flags in break
// R6 - a flag cleared in break stays cleared afterwards
// R7 - two-step clears stay protected in break, second step works after
// R8 - wait or stop instruction clears the cpu interrupt mask
// R9 - wait stops cpu clocks, peripheral clocks keep running
// R10 - enabled interrupt wakes wait; stacking one cycle later
// R11 - reset or break ends wait; break sets break exited wait flag
// R12 - watchdog enabled and running in wait when disable bit is 0
// R13 - stop clears internal counter and gates both generator clocks
// R14 - interrupt, reset or break ends stop; stacking after recovery
// R15 - recovery is 4096 crystal cycles, 32 with short recovery select
// R16 - counter held clear during stop, then times the recovery
// R17 - break exited wait flag cleared by reset or writing 0
// R18 - reading reset source status clears all its flags
// R19 - power-on sets only its flag; others set own flag, keep rest; the code also sets the low voltage flag when low voltage comes with power-on
// R20 - separate flags for pin, watchdog, bad opcode, monitor, low voltage
// R21 - bad address flag only for opcode fetches
// R22 - monitor flag needs all-ones vectors and interrupt pin at supply
// R23 - service only with mask clear and enable set, after instruction ends
// R24 - reset status read returns values first, clears afterwards
module sysi_top
	import sysi_pkg::*;
#(
	parameter int REC_LONG = SYSI_REC_LONG_CYC,
	parameter int REC_SHORT = SYSI_REC_SHORT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire sysi_cfg_type cfg,
	input wire sysi_rst_src_type rst_src,
	output logic sys_reset,
	input wire logic [SYSI_NUM_IRQ:1] irq_req,
	input wire logic [SYSI_NUM_IRQ:1] irq_en,
	input wire logic cpu_i_mask,
	input wire logic cpu_insn_done,
	input wire logic cpu_wait_exec,
	input wire logic cpu_stop_exec,
	input wire logic cpu_break_exit,
	output logic cpu_i_mask_clear,
	output logic irq_stack,
	output logic [4:0] irq_vector,
	input wire logic brk_irq,
	output logic force_swi,
	output logic in_break,
	input wire logic flag_clear_req,
	output logic flag_clear_allow,
	input wire logic xtal_tick,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic gen_clk_en,
	output logic wdog_run
);

	generate
		if (REC_SHORT < 1 || REC_LONG < REC_SHORT || REC_LONG >= (1 << SYSI_CNT_W)) begin : g_bad
			$error("sysi_top: recovery lengths out of range");
		end
	endgenerate

	localparam logic [SYSI_CNT_W-1:0] LIM_LONG = SYSI_CNT_W'(REC_LONG - 1);
	localparam logic [SYSI_CNT_W-1:0] LIM_SHORT = SYSI_CNT_W'(REC_SHORT - 1);
	localparam logic [SYSI_CNT_W-1:0] CNT_ONE = SYSI_CNT_W'(1);

	sysi_state_type state_q;
	logic [SYSI_CNT_W-1:0] cnt_q;
	logic wake_brk_q;
	logic bw_q;
	logic break_clear_enable_q;
	logic in_break_q;
	logic [7:0] rss_q;
	logic [7:0] rdata_q;
	logic sys_reset_q;
	logic imask_clr_q;
	logic irq_stack_q;
	logic [4:0] irq_vec_q;
	logic force_swi_q;

	logic any_reset;
	logic [SYSI_NUM_IRQ:1] irq_live;
	logic irq_any;
	logic [4:0] irq_top;
	logic [SYSI_CNT_W-1:0] rec_lim;
	logic rec_done;
	logic rd_rss;
	logic wr_bss;
	logic wr_bfc;
	logic [7:0] rss_set;

	// equal priority: any source pulls the whole chip into reset together
	assign any_reset = rst_src.power_on | rst_src.ext_pin | rst_src.watchdog | // R3
		rst_src.bad_opcode | (rst_src.bad_fetch & rst_src.fetch_is_opcode) |
		rst_src.monitor_entry | rst_src.low_voltage;

	assign irq_live = irq_req & irq_en;
	assign irq_any = |irq_live;

	// lowest source number has highest priority
	always_comb begin
		irq_top = 5'h00;
		for (int i = SYSI_NUM_IRQ; i >= 1; i--) begin
			if (irq_live[i]) begin
				irq_top = 5'(i);
			end
		end
	end

	assign rec_lim = cfg.short_recovery_select ? LIM_SHORT : LIM_LONG; // R15
	assign rec_done = (state_q == SYSI_RECOVER) && xtal_tick && (cnt_q == rec_lim); // R15

	assign rd_rss = bus_rd && (bus_addr == SYSI_ADDR_RESET_SOURCE_STATUS);
	assign wr_bss = bus_wr && (bus_addr == SYSI_ADDR_BREAK_STATUS);
	assign wr_bfc = bus_wr && (bus_addr == SYSI_ADDR_BREAK_FLAG_CONTROL);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sys_reset_q <= 1'b0;
		end else begin
			sys_reset_q <= any_reset; // R3
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= SYSI_RUN;
			wake_brk_q <= 1'b0;
		end else if (any_reset) begin
			state_q <= SYSI_RUN; // R11 R14
			wake_brk_q <= 1'b0;
		end else begin
			case (state_q)
				SYSI_RUN: begin
					if (cpu_stop_exec) begin
						state_q <= SYSI_STOP;
					end else if (cpu_wait_exec) begin
						state_q <= SYSI_WAIT;
					end
				end
				SYSI_WAIT: begin
					if (brk_irq || irq_any) begin
						state_q <= SYSI_RUN; // R10 R11
					end
				end
				SYSI_STOP: begin
					if (brk_irq || irq_any) begin
						state_q <= SYSI_RECOVER; // R14
						wake_brk_q <= brk_irq;
					end
				end
				SYSI_RECOVER: begin
					if (rec_done) begin
						state_q <= SYSI_RUN; // R14
					end
				end
				default: begin
					state_q <= SYSI_RUN;
				end
			endcase
		end
	end

	// counter free-runs on crystal ticks, but is pinned at zero through stop
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (state_q == SYSI_STOP) begin
			cnt_q <= '0; // R13 R16
		end else if (rec_done) begin
			cnt_q <= '0;
		end else if (xtal_tick) begin
			cnt_q <= cnt_q + CNT_ONE; // R16
		end
	end

	// cpu side pulses, all registered
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			imask_clr_q <= 1'b0;
			irq_stack_q <= 1'b0;
			irq_vec_q <= 5'h00;
			force_swi_q <= 1'b0;
		end else begin
			imask_clr_q <= !any_reset && (state_q == SYSI_RUN) &&
				(cpu_wait_exec || cpu_stop_exec); // R8
			irq_stack_q <= 1'b0;
			force_swi_q <= 1'b0;
			if (!any_reset) begin
				case (state_q)
					SYSI_RUN: begin
						if (brk_irq) begin
							force_swi_q <= 1'b1; // R4
						end else if (cpu_insn_done && !cpu_i_mask && irq_any &&
							!cpu_wait_exec && !cpu_stop_exec) begin
							irq_stack_q <= 1'b1; // R23
							irq_vec_q <= irq_top;
						end
					end
					SYSI_WAIT: begin
						if (brk_irq) begin
							force_swi_q <= 1'b1; // R4 R11
						end else if (irq_any) begin
							irq_stack_q <= 1'b1; // R10
							irq_vec_q <= irq_top;
						end
					end
					SYSI_RECOVER: begin
						if (rec_done && wake_brk_q) begin
							force_swi_q <= 1'b1; // R4
						end else if (rec_done && irq_any) begin
							irq_stack_q <= 1'b1; // R14
							irq_vec_q <= irq_top;
						end
					end
					default: begin
						irq_stack_q <= 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			in_break_q <= 1'b0;
		end else if (any_reset) begin
			in_break_q <= 1'b0;
		end else if (force_swi_q) begin
			in_break_q <= 1'b1; // R4
		end else if (cpu_break_exit) begin
			in_break_q <= 1'b0;
		end
	end

	// set wins over a software clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bw_q <= 1'b0;
		end else if (any_reset) begin
			bw_q <= 1'b0; // R17
		end else if ((state_q == SYSI_WAIT) && brk_irq) begin
			bw_q <= 1'b1; // R11
		end else if (wr_bss && !bus_wdata[SYSI_BIT_BREAK_EXITED_WAIT]) begin
			bw_q <= 1'b0; // R17
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			break_clear_enable_q <= 1'b0;
		end else if (wr_bfc) begin
			break_clear_enable_q <= bus_wdata[SYSI_BIT_BREAK_CLEAR_ENABLE];
		end
	end

	// flag owners apply their own clear, and it sticks once done
	assign flag_clear_allow = flag_clear_req && (!in_break_q || break_clear_enable_q); // R5 R6 R7

	always_comb begin
		rss_set = SYSI_BYTE_ZERO;
		rss_set[SYSI_RSS_PIN] = rst_src.ext_pin; // R20
		rss_set[SYSI_RSS_WDOG] = rst_src.watchdog; // R20
		rss_set[SYSI_RSS_BAD_OPCODE] = rst_src.bad_opcode; // R20
		rss_set[SYSI_RSS_BAD_FETCH] = rst_src.bad_fetch && rst_src.fetch_is_opcode; // R21
		rss_set[SYSI_RSS_MONITOR] = rst_src.monitor_entry && rst_src.vectors_all_ones &&
			rst_src.irq_pin_at_supply; // R22
		rss_set[SYSI_RSS_LOW_VOLTAGE] = rst_src.low_voltage; // R20
	end

	// the read captures first and the clear lands in the same edge, so the
	// returned byte is the pre-clear value while a new source still sets
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rss_q <= SYSI_BYTE_ZERO;
		end else if (rst_src.power_on) begin
			rss_q <= SYSI_BYTE_ZERO;
			rss_q[SYSI_RSS_POR] <= 1'b1; // R19
			rss_q[SYSI_RSS_LOW_VOLTAGE] <= rst_src.low_voltage;
		end else if (rd_rss) begin
			rss_q <= rss_set; // R18 R24
		end else begin
			rss_q <= rss_q | rss_set; // R19
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata_q <= SYSI_BYTE_ZERO;
		end else if (bus_rd) begin
			case (bus_addr)
				SYSI_ADDR_BREAK_STATUS: begin
					rdata_q <= SYSI_BYTE_ZERO;
					rdata_q[SYSI_BIT_BREAK_EXITED_WAIT] <= bw_q;
				end
				SYSI_ADDR_RESET_SOURCE_STATUS: begin
					rdata_q <= rss_q; // R24
				end
				SYSI_ADDR_BREAK_FLAG_CONTROL: begin
					rdata_q <= SYSI_BYTE_ZERO;
					rdata_q[SYSI_BIT_BREAK_CLEAR_ENABLE] <= break_clear_enable_q;
				end
				SYSI_ADDR_PENDING_IRQ_STATUS_B: begin
					rdata_q <= {irq_req[SYSI_MID_HI:SYSI_MID_LO], 1'b0}; // R1
				end
				SYSI_ADDR_PENDING_IRQ_STATUS_C: begin
					rdata_q <= {6'h00, irq_req[SYSI_NUM_IRQ:SYSI_LOW_LO]}; // R2
				end
				default: begin
					rdata_q <= SYSI_BYTE_ZERO;
				end
			endcase
		end
	end

	assign bus_rdata = rdata_q;
	assign sys_reset = sys_reset_q;
	assign cpu_i_mask_clear = imask_clr_q;
	assign irq_stack = irq_stack_q;
	assign irq_vector = irq_vec_q;
	assign force_swi = force_swi_q;
	assign in_break = in_break_q;
	assign cpu_clk_en = (state_q == SYSI_RUN); // R9
	assign periph_clk_en = (state_q == SYSI_RUN) || (state_q == SYSI_WAIT); // R9 R13
	assign gen_clk_en = (state_q != SYSI_STOP); // R13
	assign wdog_run = !cfg.watchdog_disable && (state_q != SYSI_STOP); // R12

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_wait_entry;
		(state_q == SYSI_RUN) && cpu_wait_exec && !cpu_stop_exec && !any_reset;
	endsequence

	sequence s_wait_irq_wake;
		(state_q == SYSI_WAIT) && irq_any && !brk_irq && !any_reset;
	endsequence

	a_imask_on_entry: assert property ( // R8
		s_wait_entry |=> cpu_i_mask_clear) else $error("mask not cleared on wait entry");

	a_wait_clocks: assert property ( // R9
		s_wait_entry |=> (!cpu_clk_en && periph_clk_en)) else $error("wait clock gating wrong");

	a_wait_wake_stack: assert property ( // R10
		s_wait_irq_wake |=> irq_stack && (irq_vector == $past(irq_top)) && cpu_clk_en)
		else $error("wait wake did not stack next cycle");

	a_break_wait_flag: assert property ( // R11
		((state_q == SYSI_WAIT) && brk_irq && !any_reset) |=> bw_q && force_swi ##1 in_break)
		else $error("break exit from wait not flagged");

	a_stop_counter: assert property ( // R16
		(state_q == SYSI_STOP) |=> (cnt_q == '0) && !gen_clk_en || (state_q != SYSI_STOP))
		else $error("counter not held in stop");

	// every tick short of the limit must advance the count and keep the cpu parked
	a_recovery_len: assert property ( // R15
		((state_q == SYSI_RECOVER) && xtal_tick && (cnt_q < rec_lim) && !any_reset) |=>
		(state_q == SYSI_RECOVER) && !irq_stack && (cnt_q == $past(cnt_q) + CNT_ONE))
		else $error("recovery ended early or skipped a tick");

	a_rss_read_clear: assert property ( // R24
		(rd_rss && !rst_src.power_on && (rss_set == SYSI_BYTE_ZERO)) |=>
		(bus_rdata == $past(rss_q)) && (rss_q == SYSI_BYTE_ZERO))
		else $error("reset status read did not return then clear");

	a_por_only: assert property ( // R19
		(rst_src.power_on && !rst_src.low_voltage) |=> (rss_q == 8'h80))
		else $error("power-on did not leave only its flag");

	a_break_protect: assert property ( // R5
		(in_break_q && !break_clear_enable_q) |-> !flag_clear_allow) else $error("flag clear leaked in break");

	a_irq_mask: assert property ( // R23
		(state_q == SYSI_RUN && cpu_i_mask && !brk_irq) |=> !irq_stack)
		else $error("interrupt taken while masked");

	a_pend_b: assert property ( // R1
		(bus_rd && bus_addr == SYSI_ADDR_PENDING_IRQ_STATUS_B) |=>
		bus_rdata == {$past(irq_req[SYSI_MID_HI:SYSI_MID_LO]), 1'b0})
		else $error("pending register b wrong");

endmodule

//--- hw/sysi_pkg.sv
package sysi_pkg;
	// register addresses on the cpu data bus
	localparam logic [15:0] SYSI_ADDR_BREAK_STATUS = 16'hFE00;
	localparam logic [15:0] SYSI_ADDR_RESET_SOURCE_STATUS = 16'hFE01;
	localparam logic [15:0] SYSI_ADDR_BREAK_FLAG_CONTROL = 16'hFE03;
	localparam logic [15:0] SYSI_ADDR_PENDING_IRQ_STATUS_B = 16'hFE05;
	localparam logic [15:0] SYSI_ADDR_PENDING_IRQ_STATUS_C = 16'hFE06;

	// field positions
	localparam int SYSI_BIT_BREAK_EXITED_WAIT = 1;
	localparam int SYSI_BIT_BREAK_CLEAR_ENABLE = 7;

	// reset source status layout, bit 7 down to bit 1, bit 0 reads zero
	localparam int SYSI_RSS_POR = 7;
	localparam int SYSI_RSS_PIN = 6;
	localparam int SYSI_RSS_WDOG = 5;
	localparam int SYSI_RSS_BAD_OPCODE = 4;
	localparam int SYSI_RSS_BAD_FETCH = 3;
	localparam int SYSI_RSS_MONITOR = 2;
	localparam int SYSI_RSS_LOW_VOLTAGE = 1;

	// interrupt source numbering: 1 highest, 16 lowest
	localparam int SYSI_NUM_IRQ = 16;
	localparam int SYSI_MID_LO = 8;
	localparam int SYSI_MID_HI = 14;
	localparam int SYSI_LOW_LO = 15;

	localparam logic [7:0] SYSI_BYTE_ZERO = 8'h00;

	// stop recovery in crystal clock cycles
	localparam int SYSI_REC_LONG_CYC = 4096;
	localparam int SYSI_REC_SHORT_CYC = 32;
	localparam int SYSI_CNT_W = 13;

	typedef enum logic [1:0] {SYSI_RUN, SYSI_WAIT, SYSI_STOP, SYSI_RECOVER} sysi_state_type;

	typedef struct packed {
		logic power_on;
		logic ext_pin;
		logic watchdog;
		logic bad_opcode;
		logic bad_fetch;
		logic fetch_is_opcode;
		logic monitor_entry;
		logic vectors_all_ones;
		logic irq_pin_at_supply;
		logic low_voltage;
	} sysi_rst_src_type;

	typedef struct packed {
		logic watchdog_disable;
		logic short_recovery_select;
	} sysi_cfg_type;
endpackage

//--- verif/sysi_xtal_model.sv
`timescale 1ns/10ps
// crystal clock as seen from the bus clock domain: one tick every DIV cycles
module sysi_xtal_model #(
	parameter int DIV = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic gen_clk_en,
	output logic xtal_tick
);
	logic [7:0] div_q;

	// the generator output is gated off in stop, but a tick registered on the entry edge can still show in the first stop cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !gen_clk_en) begin
			div_q <= 8'h00;
			xtal_tick <= 1'b0;
		end else begin
			div_q <= (div_q == 8'(DIV - 1)) ? 8'h00 : div_q + 8'h01;
			xtal_tick <= (div_q == 8'(DIV - 1));
		end
	end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/10ps
module tb_top
	import sysi_pkg::*;
;
	localparam int RL = 8;
	localparam int RS = 2;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] bus_rdata;
	sysi_cfg_type cfg = '0;
	sysi_rst_src_type rst_src = '0;
	logic sys_reset;
	logic [SYSI_NUM_IRQ:1] irq_req = '0;
	logic [SYSI_NUM_IRQ:1] irq_en = '1;
	logic cpu_i_mask = 1'b0;
	logic cpu_insn_done = 1'b0;
	logic cpu_wait_exec = 1'b0;
	logic cpu_stop_exec = 1'b0;
	logic cpu_break_exit = 1'b0;
	logic cpu_i_mask_clear, irq_stack, force_swi, in_break, flag_clear_allow;
	logic [4:0] irq_vector;
	logic brk_irq = 1'b0;
	logic flag_clear_req = 1'b0;
	logic xtal_tick, cpu_clk_en, periph_clk_en, gen_clk_en, wdog_run;
	int fail_count = 0;
	int samples_checked = 0;
	int i, n, s;
	logic [9:0] src_a [10] = '{10'h201, 10'h000, 10'h100, 10'h080, 10'h040,
		10'h030, 10'h020, 10'h00E, 10'h008, 10'h001};
	logic [9:0] src_b [10] = '{10'h000, 10'h000, 10'h080, 10'h200, 10'h000,
		10'h000, 10'h000, 10'h000, 10'h000, 10'h000};
	logic [7:0] src_exp [10] = '{8'h82, 8'h00, 8'h60, 8'h80, 8'h10,
		8'h08, 8'h00, 8'h04, 8'h00, 8'h02};

	always #4 clk_sys = ~clk_sys;

	sysi_top #(.REC_LONG(RL), .REC_SHORT(RS)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .cfg(cfg), .rst_src(rst_src), .sys_reset(sys_reset),
		.irq_req(irq_req), .irq_en(irq_en), .cpu_i_mask(cpu_i_mask),
		.cpu_insn_done(cpu_insn_done), .cpu_wait_exec(cpu_wait_exec),
		.cpu_stop_exec(cpu_stop_exec), .cpu_break_exit(cpu_break_exit),
		.cpu_i_mask_clear(cpu_i_mask_clear), .irq_stack(irq_stack),
		.irq_vector(irq_vector), .brk_irq(brk_irq), .force_swi(force_swi),
		.in_break(in_break), .flag_clear_req(flag_clear_req),
		.flag_clear_allow(flag_clear_allow), .xtal_tick(xtal_tick),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
		.gen_clk_en(gen_clk_en), .wdog_run(wdog_run));

	sysi_xtal_model #(.DIV(4)) xtal (.clk_sys(clk_sys), .rst_n(rst_n),
		.gen_clk_en(gen_clk_en), .xtal_tick(xtal_tick));

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// every access lands on a falling edge and leaves one idle cycle behind it
	task automatic cyc();
		@(negedge clk_sys);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		cyc();
		bus_wr = 1'b0;
		cyc();
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e, input string m);
		bus_addr = a;
		bus_rd = 1'b1;
		cyc();
		bus_rd = 1'b0;
		chk(bus_rdata, e, m);
		cyc();
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: return irq_stack;
			1: return force_swi;
			default: return in_break;
		endcase
	endfunction

	task automatic waitf(input int w, input int lim);
		int k;
		for (k = 0; k < lim; k++) begin
			if (pick(w) === 1'b1) break;
			cyc();
		end
		samples_checked++;
		if (k == lim) begin
			fail_count++;
			$display("MISMATCH t=%0t timeout on event %0d", $time, w);
			final_report();
		end
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		cyc();
		rst_n = 1'b1;
		cyc();
		rd(SYSI_ADDR_BREAK_STATUS, 8'h00, "break status reset");
		rd(SYSI_ADDR_BREAK_FLAG_CONTROL, 8'h00, "flag control reset");
		wr(SYSI_ADDR_PENDING_IRQ_STATUS_B, 8'hFF);
		rd(SYSI_ADDR_PENDING_IRQ_STATUS_B, 8'h00, "pending b reset");
		rd(16'hFE02, 8'h00, "unmapped");
		$display("test registers done");

		for (i = 0; i < 2; i++) begin
			irq_req = (i == 0) ? 16'hA5C3 : 16'h5A3C;
			irq_en = '0;
			cyc();
			rd(SYSI_ADDR_PENDING_IRQ_STATUS_B, {irq_req[14:8], 1'b0}, "pending b");
			rd(SYSI_ADDR_PENDING_IRQ_STATUS_C, {6'h00, irq_req[16:15]}, "pending c");
		end
		irq_req = '0;
		irq_en = '1;
		$display("test pending done");

		for (i = 0; i < 10; i++) begin
			rst_src = src_a[i];
			cyc();
			rst_src = src_b[i];
			if (src_exp[i] != 8'h00) chk(sys_reset, 8'h01, "reset event");
			else if (src_a[i] == 10'h000) chk(sys_reset, 8'h00, "no reset event");
			cyc();
			rst_src = '0;
			cyc();
			rd(SYSI_ADDR_RESET_SOURCE_STATUS, src_exp[i], "reset source");
		end
		$display("test reset sources done");

		irq_req[5] = 1'b1;
		irq_req[9] = 1'b1;
		cpu_i_mask = 1'b1;
		cpu_insn_done = 1'b1;
		cyc();
		cpu_insn_done = 1'b0;
		cyc();
		chk(irq_stack, 8'h00, "masked service");
		cpu_i_mask = 1'b0;
		cpu_insn_done = 1'b1;
		cyc();
		cpu_insn_done = 1'b0;
		chk(irq_stack, 8'h01, "service");
		chk(irq_vector, 8'h05, "service vector");
		irq_req = '0;
		cyc();
		$display("test service done");

		cpu_wait_exec = 1'b1;
		cyc();
		cpu_wait_exec = 1'b0;
		chk(cpu_i_mask_clear, 8'h01, "wait mask clear");
		chk({cpu_clk_en, periph_clk_en, wdog_run}, 8'h03, "wait clocks");
		cyc();
		chk(cpu_i_mask_clear, 8'h00, "mask clear pulse");
		irq_req[3] = 1'b1;
		waitf(0, 4);
		chk(irq_vector, 8'h03, "wait wake vector");
		irq_req = '0;
		cyc();
		chk(cpu_clk_en, 8'h01, "wait exit clock");
		cfg.watchdog_disable = 1'b1;
		cyc();
		chk(wdog_run, 8'h00, "watchdog disabled");
		cfg.watchdog_disable = 1'b0;
		$display("test wait done");

		cpu_wait_exec = 1'b1;
		cyc();
		cpu_wait_exec = 1'b0;
		brk_irq = 1'b1;
		cyc();
		brk_irq = 1'b0;
		waitf(1, 3);
		waitf(2, 3);
		rd(SYSI_ADDR_BREAK_STATUS, 8'h02, "break exited wait");
		flag_clear_req = 1'b1;
		cyc();
		chk(flag_clear_allow, 8'h00, "protected in break");
		wr(SYSI_ADDR_BREAK_FLAG_CONTROL, 8'h80);
		rd(SYSI_ADDR_BREAK_FLAG_CONTROL, 8'h80, "clear enable");
		chk(flag_clear_allow, 8'h01, "clear in break");
		wr(SYSI_ADDR_BREAK_FLAG_CONTROL, 8'h00);
		cpu_break_exit = 1'b1;
		cyc();
		cpu_break_exit = 1'b0;
		cyc();
		chk(in_break, 8'h00, "break left");
		chk(flag_clear_allow, 8'h01, "second step after break");
		flag_clear_req = 1'b0;
		wr(SYSI_ADDR_BREAK_STATUS, 8'h00);
		rd(SYSI_ADDR_BREAK_STATUS, 8'h00, "break flag cleared");
		$display("test break done");

		for (s = 0; s < 2; s++) begin
			cfg.short_recovery_select = s[0];
			cpu_stop_exec = 1'b1;
			cyc();
			cpu_stop_exec = 1'b0;
			chk(cpu_i_mask_clear, 8'h01, "stop mask clear");
			chk({gen_clk_en, periph_clk_en, cpu_clk_en}, 8'h00, "stop clocks");
			repeat (3) cyc();
			irq_req[2] = 1'b1;
			n = 0;
			for (i = 0; i < 400; i++) begin
				cyc();
				if (xtal_tick === 1'b1) n++;
				if (irq_stack === 1'b1) break;
			end
			chk(i < 400, 8'h01, "stop wake");
			if (i == 400) final_report();
			chk(n, (s == 1) ? RS : RL, "recovery ticks");
			chk(irq_vector, 8'h02, "stop wake vector");
			irq_req = '0;
			cyc();
		end
		$display("test stop done");
		final_report();
	end
endmodule
